/* File: logic/edc_host_defs.svh */
// offsets, field positions, reset values and code rows for the ecc cascade controller
`ifndef EDC_HOST_DEFS_SVH
`define EDC_HOST_DEFS_SVH

// ****************************************************************
// register offsets (byte addresses, one aligned word each)
// ****************************************************************
`define REG_CTRL      8'h00
`define REG_WDATA     8'h04
`define REG_WCHK      8'h08
`define REG_STAT      8'h0C
`define REG_CORR      8'h10
`define REG_DEVDATA   8'h14
`define REG_GEN       8'h18

// ****************************************************************
// control fields and reset values
// ****************************************************************
`define CTRL_CNT_LO   1
`define CTRL_CNT_HI   3
`define CTRL_RST      32'h0000_0000
`define WDATA_RST     32'h0000_0000
`define WCHK_RST      8'h00
`define MAX_SLAVES    3'h4

// ****************************************************************
// status fields
// ****************************************************************
`define STAT_REF_LO   0
`define STAT_DEV_LO   8
`define STAT_CLS_LO   16
`define STAT_GROSS    18
`define STAT_SYN_MIS  19
`define STAT_DAT_MIS  20
`define STAT_GEN_MIS  21

// ****************************************************************
// code rows: master covers data 15..0, slave one covers 31..16
// ****************************************************************
`define MST_ROW0      16'h296B
`define MST_ROW1      16'h5AA5
`define MST_ROW2      16'h94D6
`define MST_ROW3      16'h071F
`define MST_ROW4      16'hE0F8
`define MST_ROW5      16'hFF00
`define MST_ROW6      16'h0000
`define MST_ROW7      16'h0000
`define SLV_ROW0      16'h266E
`define SLV_ROW1      16'h83A7
`define SLV_ROW2      16'h0CEE
`define SLV_ROW3      16'h19D3
`define SLV_ROW4      16'h50F3
`define SLV_ROW5      16'hE0F8
`define SLV_ROW6      16'hFF00
`define SLV_ROW7      16'h0000
`define XNOR_ROWS     8'h03

`endif

/* File: logic/edc_host_pkg.sv */
// types shared by the ecc cascade controller
package edc_host_pkg;
  typedef enum logic [1:0] {
    CLS_NONE   = 2'b00,
    CLS_SINGLE = 2'b01,
    CLS_DOUBLE = 2'b10,
    CLS_MULTI  = 2'b11
  } err_class_e;
endpackage : edc_host_pkg

/* File: logic/parity_combine.sv */
// external xor gating that merges slave partial parity toward the master
`timescale 1ns/1ns
`default_nettype none
module parity_combine #(
  parameter int N = 4,
  parameter int W = 8
) (
  input  wire logic [N-1:0]   en,
  input  wire logic [N*W-1:0] vec,
  output logic      [W-1:0]   y
);
  always_comb begin
    y = '0;
    for (int k = 0; k < N; k++) begin
      if (en[k]) begin
        y = y ^ vec[k*W +: W];
      end
    end
  end
endmodule : parity_combine
`default_nettype wire

/* File: logic/edc_host.sv */
// controller around an up-to-five-slice ecc cascade: straps, parity gating, reference check
//
// What this block does
// - up to five slices cascade for 80 data bits and 8 check bits
// - with several slaves, their partial parity is xored before the master
// - role strap high on master, low on slaves; unit strap high everywhere
// - master shared pins carry parity; slave position pins encode its index
// - slave one shows slave count on count pins; other slaves tie both high
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "edc_host_defs.svh"
module edc_host
  import edc_host_pkg::*;
#(
  parameter int NSLV = 4,
  parameter int PPW  = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [31:0]       mem_data_o,
  output logic      [7:0]        mem_chk_o,
  input  wire logic [NSLV*PPW-1:0] slave_pp_i,
  output logic      [PPW-1:0]    master_pp_o,
  input  wire logic [7:0]        master_syn_i,
  input  wire logic [7:0]        master_gen_i,
  input  wire logic [31:0]       dev_data_i,
  output logic      [NSLV:0]     role_sel_o,
  output logic      [NSLV:0]     unit_sel_o,
  output logic      [NSLV*4-1:0] slave_strap_o
);

  // ****************************************************************
  // code rows
  // ****************************************************************
  localparam logic [31:0] ROWS [8] = '{
    {`SLV_ROW0, `MST_ROW0}, {`SLV_ROW1, `MST_ROW1},
    {`SLV_ROW2, `MST_ROW2}, {`SLV_ROW3, `MST_ROW3},
    {`SLV_ROW4, `MST_ROW4}, {`SLV_ROW5, `MST_ROW5},
    {`SLV_ROW6, `MST_ROW6}, {`SLV_ROW7, `MST_ROW7}};

  function automatic logic [7:0] gen_chk(input logic [31:0] d);
    logic [7:0] c;
    c = '0;
    for (int j = 0; j < 8; j++) begin
      c[j] = ^(d & ROWS[j]);
    end
    return c ^ `XNOR_ROWS;
  endfunction : gen_chk

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic [31:0] ctrl_r;
  logic [31:0] wdata_r;
  logic [7:0]  wchk_r;
  logic [31:0] prdata_r;
  logic [31:0] stat_r;
  logic [31:0] corr_r;
  logic [31:0] devdata_r;
  logic [7:0]  gen_r;

  wire sel_ctrl  = (paddr == `REG_CTRL);
  wire sel_wdata = (paddr == `REG_WDATA);
  wire sel_wchk  = (paddr == `REG_WCHK);
  wire sel_stat  = (paddr == `REG_STAT);
  wire sel_corr  = (paddr == `REG_CORR);
  wire sel_dev   = (paddr == `REG_DEVDATA);
  wire sel_gen   = (paddr == `REG_GEN);
  wire mapped    = sel_ctrl | sel_wdata | sel_wchk | sel_stat | sel_corr | sel_dev | sel_gen;
  wire setup     = psel & ~penable;
  wire access    = psel & penable;
  wire wr_en     = access & pwrite & mapped;

  // every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = prdata_r;

  wire [31:0] rd_mux =
      sel_ctrl  ? ctrl_r :
      sel_wdata ? wdata_r :
      sel_wchk  ? {24'h00_0000, wchk_r} :
      sel_stat  ? stat_r :
      sel_corr  ? corr_r :
      sel_dev   ? devdata_r :
      sel_gen   ? {24'h00_0000, gen_r} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup) begin
      prdata_r <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= `CTRL_RST;
      wdata_r <= `WDATA_RST;
      wchk_r  <= `WCHK_RST;
    end else if (wr_en) begin
      if (sel_ctrl)  ctrl_r  <= pwdata;
      if (sel_wdata) wdata_r <= pwdata;
      if (sel_wchk)  wchk_r  <= pwdata[7:0];
    end
  end

  // ****************************************************************
  // straps and cascade wiring
  // ****************************************************************
  // an out-of-range count is clamped so the straps never show a code
  // that no slave could decode
  wire [2:0] cnt_raw = ctrl_r[`CTRL_CNT_HI:`CTRL_CNT_LO];
  wire [2:0] cnt_eff = (cnt_raw > `MAX_SLAVES) ? `MAX_SLAVES : cnt_raw;
  wire [1:0] cnt_code = (cnt_eff == 3'h0) ? 2'b11 : 2'(cnt_eff - 3'h1);
  logic [NSLV-1:0]   slv_en;
  logic [NSLV*4-1:0] strap_r;
  logic [NSLV*4-1:0] strap_nxt;

  // slave one carries the count code, the far slaves their position code
  genvar k;
  generate
    for (k = 0; k < NSLV; k++) begin : g_slv
      assign slv_en[k] = (k < int'(cnt_eff));
      if (k == 0) begin : g_first
        assign strap_nxt[k*4 +: 4] = {cnt_code, 2'b00};
      end else begin : g_far
        assign strap_nxt[k*4 +: 4] = {2'b11, 2'(k)};
      end
    end
  endgenerate

  // one process owns the whole strap register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_r <= {NSLV{4'hF}};
    end else begin
      strap_r <= strap_nxt;
    end
  end

  assign slave_strap_o = strap_r;
  assign role_sel_o    = {{NSLV{1'b0}}, 1'b1};
  assign unit_sel_o    = {(NSLV+1){1'b1}};
  assign mem_data_o    = wdata_r;
  // stored check bits go to the master slice only
  assign mem_chk_o     = wchk_r;

  parity_combine #(
    .N (NSLV),
    .W (PPW)
  ) u_pp (
    .en  (slv_en),
    .vec (slave_pp_i),
    .y   (master_pp_o)
  );

  // ****************************************************************
  // reference syndrome, classification and correction
  // ****************************************************************
  wire [7:0]  ref_gen = gen_chk(wdata_r);
  wire [7:0]  ref_syn = ref_gen ^ wchk_r;
  logic [31:0] hit;

  generate
    for (k = 0; k < 32; k++) begin : g_col
      wire [7:0] col = {ROWS[7][k], ROWS[6][k], ROWS[5][k], ROWS[4][k],
                        ROWS[3][k], ROWS[2][k], ROWS[1][k], ROWS[0][k]};
      assign hit[k] = (ref_syn == col);
    end
  endgenerate

  wire chk_hit    = $onehot(ref_syn);
  wire data_hit   = |hit;
  wire even_w     = ~^ref_syn;
  wire [1:0] cls  = (ref_syn == 8'h00)   ? CLS_NONE :
                    (data_hit | chk_hit) ? CLS_SINGLE :
                    even_w               ? CLS_DOUBLE : CLS_MULTI;
  wire gross      = ((wdata_r == 32'h0000_0000) && (wchk_r == 8'h00)) ||
                    ((wdata_r == 32'hFFFF_FFFF) && (wchk_r == 8'hFF));
  wire [31:0] corr = (cls == CLS_SINGLE) ? (wdata_r ^ hit) : wdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r    <= 32'h0000_0000;
      corr_r    <= 32'h0000_0000;
      devdata_r <= 32'h0000_0000;
      gen_r     <= 8'h00;
    end else begin
      stat_r    <= {10'h000, master_gen_i != ref_gen, dev_data_i != corr,
                    master_syn_i != ref_syn, gross, cls, master_syn_i, ref_syn};
      corr_r    <= corr;
      devdata_r <= dev_data_i;
      gen_r     <= ref_gen;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  // checks start one edge after release, once every register has left reset
  logic asrt_arm_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asrt_arm_r <= 1'b0;
    end else begin
      asrt_arm_r <= 1'b1;
    end
  end

  default clocking cb_main @(posedge pclk); endclocking
  default disable iff (!presetn || !asrt_arm_r);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  chk_wdata_lands: assert property (s_setup ##1 (s_access && pready && pwrite && sel_wdata)
                                    |=> mem_data_o == $past(pwdata))
    else $error("data word write did not land");
  chk_pp_gating: assert property (master_pp_o == ((slv_en[0] ? slave_pp_i[PPW-1:0] : '0)
                                   ^ (slv_en[1] ? slave_pp_i[2*PPW-1:PPW] : '0)
                                   ^ (slv_en[2] ? slave_pp_i[3*PPW-1:2*PPW] : '0)
                                   ^ (slv_en[3] ? slave_pp_i[4*PPW-1:3*PPW] : '0)))
    else $error("partial parity gating wrong");
  chk_role_strap: assert property (role_sel_o[0] && !(|role_sel_o[NSLV:1]) && &unit_sel_o)
    else $error("role or unit strap wrong");
  chk_count_code: assert property (wr_en && sel_ctrl && pwdata[3:1] == 3'h3
                                   ##1 1'b1 |=> slave_strap_o[3:0] == 4'b1000)
    else $error("slave one count strap wrong");
  chk_slave_pos: assert property ($rose(presetn) |=> slave_strap_o[7:4] == 4'b1101
                                   && slave_strap_o[11:8] == 4'b1110)
    else $error("slave position strap wrong");
  chk_class_none: assert property (ref_syn == 8'h00 && !$changed(wdata_r)
                                   |=> stat_r[17:16] == CLS_NONE)
    else $error("zero syndrome not classed as none");
  chk_gross_flag: assert property (wdata_r == 32'h0000_0000 && wchk_r == 8'h00
                                   |=> stat_r[`STAT_GROSS])
    else $error("gross error not flagged");
  chk_single_flip: assert property (cls == CLS_SINGLE && data_hit
                                    |=> $onehot(corr_r ^ $past(wdata_r)))
    else $error("single error not one flipped bit");
  chk_xnor_rows: assert property (wdata_r == 32'h0000_0000 |-> ref_gen == 8'h03)
    else $error("xnor rows wrong for zero data");
  chk_gen_track: assert property (##1 gen_r == $past(ref_gen))
    else $error("generated check bits not captured");

endmodule : edc_host
`default_nettype wire

/* File: sim/slice_pair_model.sv */
// behavioural master slice, slave one and the far slaves of the cascade
`timescale 1ns/1ns
`default_nettype none
`include "edc_host_defs.svh"
module slice_pair_model (
  input  wire logic [31:0] data,
  input  wire logic [7:0]  chk,
  input  wire logic [7:0]  pp_in,
  input  wire logic [23:0] far_pp,
  output logic      [31:0] slave_pp,
  output logic      [7:0]  syn,
  output logic      [7:0]  gen,
  output logic      [31:0] fix
);
  localparam logic [127:0] mst_rows = {`MST_ROW7, `MST_ROW6, `MST_ROW5, `MST_ROW4,
                                       `MST_ROW3, `MST_ROW2, `MST_ROW1, `MST_ROW0};
  localparam logic [127:0] slv_rows = {`SLV_ROW7, `SLV_ROW6, `SLV_ROW5, `SLV_ROW4,
                                       `SLV_ROW3, `SLV_ROW2, `SLV_ROW1, `SLV_ROW0};
  localparam logic [7:0]   xnor_rows = `XNOR_ROWS;
  // slave parity kept apart from the master block so a self-fed pp_in cannot loop
  always_comb begin
    for (int r = 0; r < 8; r++) begin
      slave_pp[r] = ^(data[31:16] & slv_rows[r*16+:16]);
    end
    slave_pp[31:8] = far_pp;
  end
  always_comb begin
    logic [7:0] col;
    col = 8'h00;
    for (int r = 0; r < 8; r++) begin
      gen[r] = ^(data[15:0] & mst_rows[r*16+:16]);
      gen[r] = gen[r] ^ pp_in[r] ^ xnor_rows[r];
    end
    syn = gen ^ chk;
    for (int i = 0; i < 32; i++) begin
      for (int r = 0; r < 8; r++) begin
        col[r] = (i < 16) ? mst_rows[r*16+i] : slv_rows[r*16+i-16];
      end
      fix[i] = data[i] ^ (syn == col);
    end
  end
endmodule : slice_pair_model
`default_nettype wire

/* File: sim/cascaded_hamming_edc_tb.sv */
// self-checking bench for the ecc cascade controller
`timescale 1ns/1ns
`default_nettype none
`include "edc_host_defs.svh"
module cascaded_hamming_edc_tb;
  typedef struct {logic [31:0] m; logic [31:0] d; logic e;} note_s;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, gross;
  logic [7:0]  paddr, mchk, mpp, msyn, mgen, c, x, rc0, rc1, g0, s0, g1, s1;
  logic [31:0] pwdata, prdata, mdat, ddat, rd_d, d, spp, f0, f1, p0, p1;
  logic [23:0] far_pp;
  logic [4:0]  role, unit;
  logic [15:0] strap;
  logic [39:0] e;
  logic [1:0]  cls;
  int          seed, failures, tests_run, cycles, cnt, b;
  note_s       notes[$];
  note_s       nt;

  always #5 pclk = ~pclk;
  edc_host i_edc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_data_o(mdat), .mem_chk_o(mchk), .slave_pp_i(spp),
    .master_pp_o(mpp), .master_syn_i(msyn), .master_gen_i(mgen), .dev_data_i(ddat),
    .role_sel_o(role), .unit_sel_o(unit), .slave_strap_o(strap));
  slice_pair_model i_slice_pair_model (.data(mdat), .chk(mchk), .pp_in(mpp), .far_pp(far_pp),
    .slave_pp(spp), .syn(msyn), .gen(mgen), .fix(ddat));
  // references: full 32-bit code, then the same word with the cascade's extra parity
  slice_pair_model i_ref0 (.data(rd_d), .chk(rc0), .pp_in(p0[7:0]), .far_pp(24'h0),
    .slave_pp(p0), .syn(s0), .gen(g0), .fix(f0));
  slice_pair_model i_ref1 (.data(rd_d), .chk(rc1), .pp_in(p1[7:0]), .far_pp(24'h0),
    .slave_pp(p1), .syn(s1), .gen(g1), .fix(f1));

  // ****************************************************************
  // compare, bus and closing tasks
  // ****************************************************************
  task automatic compare(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      input logic [31:0] m, input logic [31:0] ed, input logic ee);
    notes.push_back('{m, ed, ee});
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
  endtask : xfer

  task automatic idle(input int n);
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : idle

  task automatic end_of_test();
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // monitor: oldest note against each completed transfer
  // ****************************************************************
  always @(posedge pclk) begin
    cycles++;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      nt = notes.pop_front();
      compare({8'h0, prdata & nt.m}, {8'h0, nt.d});
      compare({39'h0, pslverr}, {39'h0, nt.e});
    end
    // whole run is near 1050 cycles
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = 24996;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata, far_pp, rd_d, rc0, rc1} = '0;
    repeat (5) @(posedge pclk);
    compare({24'h0, strap}, 40'h00_0000_FFFF);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(`REG_CTRL, 1'b0, 32'h0, '1, 32'h0, 1'b0);
    xfer(`REG_WDATA, 1'b0, 32'h0, '1, 32'h0, 1'b0);
    xfer(`REG_WCHK, 1'b0, 32'h0, '1, 32'h0, 1'b0);
    xfer(8'h1C, 1'b1, '1, 32'h0, 32'h0, 1'b1);
    xfer(8'h1C, 1'b0, 32'h0, '1, 32'h0, 1'b1);
    for (int n = 0; n < 6; n++) begin
      cnt = (n > 4) ? 4 : n;
      xfer(`REG_CTRL, 1'b1, (n > 4) ? 32'h0000_000E : 32'(n << 1), 32'h0, 32'h0, 1'b0);
      idle(2);
      compare({24'h0, strap},
              {24'h0, 12'hFED, (cnt == 0) ? 2'b11 : 2'(cnt - 1), 2'b00});
      compare({30'h0, unit, role}, {30'h0, 5'h1F, 5'h01});
      for (int t = 0; t < 8; t++) begin
        far_pp <= 24'($random(seed));
        d = (t == 0) ? 32'h0 : (t == 1) ? '1 : $random(seed);
        rd_d = d;
        #1;
        c = (t == 0) ? 8'h00 : (t == 1) ? 8'hFF : g0;
        b = $unsigned($random(seed)) % 32;
        case (t)
          3: e = 40'h1 << b;
          4: e = 40'h1 << (32 + b % 8);
          5: e = 40'h3 << b;
          6, 7: e = {8'($random(seed)), 32'($random(seed))};
          default: e = 40'h0;
        endcase
        {c, d} = {c, d} ^ e;
        rd_d = d;
        rc0 = c;
        // let the reference slave parity follow the corrupted word
        #1;
        x = (cnt == 0) ? p0[7:0] : 8'h00;
        for (int k = 1; k < cnt; k++) x ^= far_pp[(k-1)*8+:8];
        rc1 = c ^ x;
        #1;
        gross = (d == 32'h0 && c == 8'h00) || (d == '1 && c == 8'hFF);
        cls = (s0 == 8'h0) ? 2'd0 : (f0 !== d || $onehot(s0)) ? 2'd1 : (^s0) ? 2'd3 : 2'd2;
        @(posedge pclk);
        xfer(`REG_WDATA, 1'b1, d, 32'h0, 32'h0, 1'b0);
        xfer(`REG_WCHK, 1'b1, {24'h0, c}, 32'h0, 32'h0, 1'b0);
        xfer(`REG_STAT, 1'b1, $random(seed), 32'h0, 32'h0, 1'b0);
        idle(3);
        xfer(`REG_STAT, 1'b0, 32'h0, '1, {10'h0, x != 0, f1 != f0, x != 0, gross, cls, s1, s0},
             1'b0);
        xfer(`REG_CORR, 1'b0, 32'h0, '1, f0, 1'b0);
        xfer(`REG_DEVDATA, 1'b0, 32'h0, '1, f1, 1'b0);
        xfer(`REG_GEN, 1'b0, 32'h0, '1, {24'h0, g0}, 1'b0);
        xfer(`REG_WCHK, 1'b0, 32'h0, '1, {24'h0, c}, 1'b0);
        idle(1);
      end
    end
    end_of_test();
  end
endmodule : cascaded_hamming_edc_tb
`default_nettype wire
